// ### design/sslsp_defs.vh
`ifndef SSLSP_DEFS_VH
`define SSLSP_DEFS_VH

// Register byte offsets on the Wishbone slave
`define SSLSP_REG_GLOBAL       6'h00
`define SSLSP_REG_QUEUES       6'h04
`define SSLSP_REG_PORT_BASE    6'h08
`define SSLSP_REG_STATUS       6'h0c
`define SSLSP_REG_STORM_BASE   6'h10
`define SSLSP_REG_STORM_STRIDE 6'h04
`define SSLSP_REG_COUNT        6'h20
`define SSLSP_REG_PORT_SEL     6'h24

// Per-port config field positions
`define SSLSP_PC_LEARN_EN   0
`define SSLSP_PC_AUTO       1
`define SSLSP_PC_LCOPY      2
`define SSLSP_PC_LDROP      3
`define SSLSP_PC_LIMCOPY    4
`define SSLSP_PC_LIMDROP    5
`define SSLSP_PC_MVCOPY     6
`define SSLSP_PC_MVDROP     7
`define SSLSP_PC_WIDTH      8
`define SSLSP_PC_RESET      8'h01

// Storm config fields: rate exponent [3:0], unit [4], mode [6:5], burst [31:16]
`define SSLSP_ST_RATE_LSB   0
`define SSLSP_ST_RATE_MSB   3
`define SSLSP_ST_UNIT       4
`define SSLSP_ST_MODE_LSB   5
`define SSLSP_ST_MODE_MSB   6
`define SSLSP_ST_BURST_LSB  16
`define SSLSP_ST_BURST_MSB  31
`define SSLSP_ST_RESET      32'h0001_0000
`define SSLSP_MAX_RATE_EXP  4'ha

// Storm modes
`define SSLSP_MODE_PROCESSOR_QUEUE_MASK     2'h0
`define SSLSP_MODE_DESTINATION_PORT_MASK     2'h1
`define SSLSP_MODE_BOTH     2'h2

// Storm policer indices
`define SSLSP_POL_BC        0
`define SSLSP_POL_MC        1
`define SSLSP_POL_UC        2
`define SSLSP_POL_LRN       3

// Timing, multicast address bit and broadcast address
`define SSLSP_CLK_HZ        200000000
`define SSLSP_KILO          1000
`define SSLSP_MC_BIT        40
`define SSLSP_BCAST         48'hffffffffffff

`endif

// ### design/sslsp_core.v
// Contract
// - Search backbone or customer table for source address and VLAN; honour learn-disable flag.
// - Port learning enable cleared skips all learn options for that port.
// - Normal learn: no entry, or unlocked entry elsewhere, limit not exceeded.
// - Limit-exceeding learn: normal learn conditions but entry limit exceeded.
// - Locked move: locked entry whose destination index differs from logical port.
// - Ingress policer learning suppression blocks all learn processing.
// - Normal learn with auto-learn inserts entry into searched table domain.
// - Normal learn with learn-drop clears destination mask.
// - Normal learn with learn-copy adds processor port and learn queue.
// - Limit-exceeding learn with limit-drop clears destination mask.
// - Limit-exceeding learn with limit-copy adds processor port and learn queue.
// - Locked move with move-drop clears destination mask.
// - Locked move with move-copy adds processor port and move queue.
// - Source hit: discard flag clears mask; copy flag adds address-copy queue.
// - Global ignore-source-flags skips entry flag adjustments.
// - Four switch-wide storm policers measure aggregate rates.
// - Frame hitting several policers is discarded if any exceeds.
// - Broadcast, multicast, unicast flooded frames and processor learn frames map to policers.
// - Rate unit one or one thousand frames/s times power of two up to 1024.
// - Overall rate spans one to about one million frames per second.
// - Each policer has a burst size in frames.
// - Per-policer mode clears queue mask, destination mask, or both.
// - Destination group holding processor port still reaches processor when policed.
//
// Chosen here: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "sslsp_defs.vh"

module sslsp_core #(
  parameter NPORT   = 12,
  parameter NQ      = 8,
  parameter PW      = 4,
  parameter CPU_BIT = 11,
  parameter CLK_HZ  = `SSLSP_CLK_HZ
) (
  // Clock and reset
  input  wire              clk_i,
  input  wire              rst_i,
  // Wishbone slave
  input  wire              wb_cyc_i,
  input  wire              wb_stb_i,
  input  wire              wb_we_i,
  input  wire [5:0]        wb_adr_i,
  input  wire [3:0]        wb_sel_i,
  input  wire [31:0]       wb_dat_i,
  output reg  [31:0]       wb_dat_o,
  output reg               wb_ack_o,
  // Frame from earlier step
  input  wire              frm_valid_i,
  input  wire [PW-1:0]     physical_ingress_port_i,
  input  wire [PW-1:0]     logical_ingress_port_i,
  input  wire              backbone_domain_i,
  input  wire [47:0]       source_station_address_i,
  input  wire [47:0]       destination_port_mask_station_address_i,
  input  wire [11:0]       vid_i,
  input  wire              learn_disable_flag_i,
  input  wire              policer_no_learn_i,
  input  wire              flooded_i,
  input  wire              port_group_table_has_cpu_i,
  input  wire [NPORT-1:0]  destination_port_mask_i,
  input  wire [NQ-1:0]     processor_queue_mask_i,
  // Source lookup result
  input  wire              entry_hit_i,
  input  wire              entry_locked_i,
  input  wire [PW-1:0]     entry_destination_index_i,
  input  wire              source_discard_flag_i,
  input  wire              entry_copy_to_processor_i,
  input  wire              limit_exceeded_i,
  // Lookup request
  output reg               lookup_req_o,
  output reg               lookup_backbone_o,
  output reg  [47:0]       lookup_addr_o,
  output reg  [11:0]       lookup_vid_o,
  // Learn insert
  output reg               learn_insert_o,
  output reg               learn_backbone_o,
  output reg  [47:0]       learn_addr_o,
  output reg  [11:0]       learn_vid_o,
  output reg  [PW-1:0]     learn_port_o,
  // Adjusted frame to next step
  output reg               out_valid_o,
  output reg               out_learn_frame_o,
  output reg  [NPORT-1:0]  destination_port_mask_o,
  output reg  [NQ-1:0]     processor_queue_mask_o
);

  localparam NPC = 1 << PW;

  // Configuration and status
  reg              ignore_source_entry_flags_ff;
  reg [2:0]        learn_extract_queue_ff;
  reg [2:0]        locked_move_extract_queue_ff;
  reg [2:0]        address_copy_extract_queue_ff;
  reg [PW-1:0]     port_sel_ff;
  reg [`SSLSP_PC_WIDTH-1:0] port_cfg_ff [0:NPC-1];
  reg [31:0]       storm_cfg_ff [0:3];
  reg [31:0]       tok_ff [0:3];
  reg [31:0]       tick_ff [0:3];
  reg [3:0]        storm_hit_ff;
  reg [15:0]       police_cnt_ff;

  // Frame rate in frames per second for a given config word
  function [31:0] rate_fps;
    input [31:0] cfg;
    reg   [31:0] base;
    begin
      base = cfg[`SSLSP_ST_UNIT] ? `SSLSP_KILO : 32'h1;
      if (cfg[`SSLSP_ST_RATE_MSB:`SSLSP_ST_RATE_LSB] > `SSLSP_MAX_RATE_EXP)
        rate_fps = base << `SSLSP_MAX_RATE_EXP;
      else
        rate_fps = base << cfg[`SSLSP_ST_RATE_MSB:`SSLSP_ST_RATE_LSB];
    end
  endfunction

  // One-hot processor queue bit for a configured queue number
  function [NQ-1:0] make_mask;
    input [2:0] idx;
    begin
      make_mask = {{(NQ-1){1'b0}}, 1'b1} << idx;
    end
  endfunction

  // Learn classification, combinational on the incoming frame
  reg [`SSLSP_PC_WIDTH-1:0] pc;
  reg              learn_ok;
  reg              moved;
  reg              is_normal;
  reg              is_limit;
  reg              is_lock;
  reg              learn_to_cpu;
  reg              insert;
  reg [NPORT-1:0]  dst;
  reg [NQ-1:0]     cq;
  reg [3:0]        activ;
  reg [3:0]        over;
  reg              police;
  reg              clr_dst;
  reg              clr_cq;
  reg [1:0]        mode_sel;
  integer          k;

  always @* begin
    pc       = port_cfg_ff[physical_ingress_port_i];
    learn_ok = pc[`SSLSP_PC_LEARN_EN] && !learn_disable_flag_i && !policer_no_learn_i;
    moved    = entry_destination_index_i != logical_ingress_port_i;
    is_normal = learn_ok && (!entry_hit_i || (!entry_locked_i && moved))
                && !limit_exceeded_i;
    is_limit = learn_ok && (!entry_hit_i || (!entry_locked_i && moved))
               && limit_exceeded_i;
    is_lock  = learn_ok && entry_hit_i && entry_locked_i && moved;
    insert   = is_normal && pc[`SSLSP_PC_AUTO];
    dst      = destination_port_mask_i;
    cq       = processor_queue_mask_i;
    learn_to_cpu = 1'b0;
    if (is_normal && pc[`SSLSP_PC_LDROP])
      dst = {NPORT{1'b0}};
    if (is_limit && pc[`SSLSP_PC_LIMDROP])
      dst = {NPORT{1'b0}};
    if (is_lock && pc[`SSLSP_PC_MVDROP])
      dst = {NPORT{1'b0}};
    if ((is_normal && pc[`SSLSP_PC_LCOPY]) || (is_limit && pc[`SSLSP_PC_LIMCOPY])) begin
      dst[CPU_BIT] = 1'b1;
      cq = cq | make_mask(learn_extract_queue_ff);
      learn_to_cpu = 1'b1;
    end
    if (is_lock && pc[`SSLSP_PC_MVCOPY]) begin
      dst[CPU_BIT] = 1'b1;
      cq = cq | make_mask(locked_move_extract_queue_ff);
      learn_to_cpu = 1'b1;
    end
    if (entry_hit_i && !ignore_source_entry_flags_ff) begin
      if (source_discard_flag_i)
        dst = {NPORT{1'b0}};
      if (entry_copy_to_processor_i)
        cq = cq | make_mask(address_copy_extract_queue_ff);
    end
    activ = 4'h0;
    if (flooded_i) begin
      if (destination_port_mask_station_address_i == `SSLSP_BCAST)
        activ[`SSLSP_POL_BC] = 1'b1;
      else if (destination_port_mask_station_address_i[`SSLSP_MC_BIT])
        activ[`SSLSP_POL_MC] = 1'b1;
      else
        activ[`SSLSP_POL_UC] = 1'b1;
    end
    activ[`SSLSP_POL_LRN] = learn_to_cpu;
    // police when bucket already holds burst count
    for (k = 0; k < 4; k = k + 1)
      over[k] = activ[k] && (tok_ff[k] >=
                {16'h0, storm_cfg_ff[k][`SSLSP_ST_BURST_MSB:`SSLSP_ST_BURST_LSB]});
    police = |over;
    // Exceeding policers with different modes add up to clearing both
    clr_dst = 1'b0;
    clr_cq  = 1'b0;
    for (k = 0; k < 4; k = k + 1) begin
      mode_sel = storm_cfg_ff[k][`SSLSP_ST_MODE_MSB:`SSLSP_ST_MODE_LSB];
      if (over[k]) begin
        case (mode_sel)
          `SSLSP_MODE_PROCESSOR_QUEUE_MASK: clr_cq = 1'b1;
          `SSLSP_MODE_DESTINATION_PORT_MASK: clr_dst = 1'b1;
          default: begin
            clr_cq  = 1'b1;
            clr_dst = 1'b1;
          end
        endcase
      end
    end
    if (police) begin
      if (clr_dst)
        dst = port_group_table_has_cpu_i ? (dst & ({{(NPORT-1){1'b0}}, 1'b1} << CPU_BIT))
                             : {NPORT{1'b0}};
      if (clr_cq && !port_group_table_has_cpu_i)
        cq = {NQ{1'b0}};
    end
  end

  // Frame outputs, registered one cycle behind the input
  always @(posedge clk_i) begin
    if (rst_i) begin
      lookup_req_o            <= 1'b0;
      lookup_backbone_o       <= 1'b0;
      lookup_addr_o           <= 48'h0;
      lookup_vid_o            <= 12'h0;
      learn_insert_o          <= 1'b0;
      learn_backbone_o        <= 1'b0;
      learn_addr_o            <= 48'h0;
      learn_vid_o             <= 12'h0;
      learn_port_o            <= {PW{1'b0}};
      out_valid_o             <= 1'b0;
      out_learn_frame_o       <= 1'b0;
      destination_port_mask_o <= {NPORT{1'b0}};
      processor_queue_mask_o  <= {NQ{1'b0}};
    end else begin
      // every frame issues a lookup in the chosen domain
      lookup_req_o            <= frm_valid_i;
      lookup_backbone_o       <= backbone_domain_i;
      lookup_addr_o           <= source_station_address_i;
      lookup_vid_o            <= vid_i;
      learn_insert_o          <= frm_valid_i && insert;
      learn_backbone_o        <= backbone_domain_i;
      learn_addr_o            <= source_station_address_i;
      learn_vid_o             <= vid_i;
      learn_port_o            <= logical_ingress_port_i;
      out_valid_o             <= frm_valid_i;
      out_learn_frame_o       <= frm_valid_i && (is_normal || is_limit || is_lock);
      destination_port_mask_o <= dst;
      processor_queue_mask_o  <= cq;
    end
  end

  // Token buckets: each unpoliced frame of the bucket's class adds a token, refill drains at the configured rate
  integer j;
  always @(posedge clk_i) begin
    if (rst_i) begin
      for (j = 0; j < 4; j = j + 1) begin
        tok_ff[j]  <= 32'h0;
        tick_ff[j] <= 32'h0;
      end
      storm_hit_ff  <= 4'h0;
      police_cnt_ff <= 16'h0;
    end else begin
      for (j = 0; j < 4; j = j + 1) begin
        // Accumulate rate each cycle; one token leaves per CLK_HZ of credit
        if (tick_ff[j] + rate_fps(storm_cfg_ff[j]) >= CLK_HZ) begin
          tick_ff[j] <= tick_ff[j] + rate_fps(storm_cfg_ff[j]) - CLK_HZ;
          if (frm_valid_i && activ[j] && !police)
            tok_ff[j] <= tok_ff[j];
          else if (tok_ff[j] != 32'h0)
            tok_ff[j] <= tok_ff[j] - 32'h1;
        end else begin
          tick_ff[j] <= tick_ff[j] + rate_fps(storm_cfg_ff[j]);
          // Policed frames are discarded and so add no token
          if (frm_valid_i && activ[j] && !police)
            tok_ff[j] <= tok_ff[j] + 32'h1;
        end
      end
      if (frm_valid_i && police) begin
        storm_hit_ff  <= storm_hit_ff | over;
        police_cnt_ff <= police_cnt_ff + 16'h1;
      end
      if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
          wb_adr_i == `SSLSP_REG_STATUS && wb_sel_i[0])
        storm_hit_ff <= (frm_valid_i && police) ? over : 4'h0;
    end
  end

  // Wishbone slave: single-cycle ack after the request is seen
  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wb_wr  = wb_req && wb_we_i;
  integer i;

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o                      <= 1'b0;
      wb_dat_o                      <= 32'h0;
      ignore_source_entry_flags_ff  <= 1'b0;
      learn_extract_queue_ff        <= 3'h0;
      locked_move_extract_queue_ff  <= 3'h0;
      address_copy_extract_queue_ff <= 3'h0;
      port_sel_ff                   <= {PW{1'b0}};
      for (i = 0; i < NPC; i = i + 1)
        port_cfg_ff[i] <= `SSLSP_PC_RESET;
      for (i = 0; i < 4; i = i + 1)
        storm_cfg_ff[i] <= `SSLSP_ST_RESET;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0;
      if (wb_wr && wb_adr_i == `SSLSP_REG_GLOBAL && wb_sel_i[0])
        ignore_source_entry_flags_ff <= wb_dat_i[0];
      if (wb_wr && wb_adr_i == `SSLSP_REG_QUEUES && wb_sel_i[0]) begin
        learn_extract_queue_ff        <= wb_dat_i[2:0];
        locked_move_extract_queue_ff  <= wb_dat_i[6:4];
      end
      if (wb_wr && wb_adr_i == `SSLSP_REG_QUEUES && wb_sel_i[1])
        address_copy_extract_queue_ff <= wb_dat_i[10:8];
      if (wb_wr && wb_adr_i == `SSLSP_REG_PORT_SEL && wb_sel_i[0])
        port_sel_ff <= wb_dat_i[PW-1:0];
      if (wb_wr && wb_adr_i == `SSLSP_REG_PORT_BASE && wb_sel_i[0])
        port_cfg_ff[port_sel_ff] <= wb_dat_i[`SSLSP_PC_WIDTH-1:0];
      for (i = 0; i < 4; i = i + 1) begin
        if (wb_wr && wb_adr_i == `SSLSP_REG_STORM_BASE + i * `SSLSP_REG_STORM_STRIDE) begin
          if (wb_sel_i[0])
            storm_cfg_ff[i][7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[2])
            storm_cfg_ff[i][23:16] <= wb_dat_i[23:16];
          if (wb_sel_i[3])
            storm_cfg_ff[i][31:24] <= wb_dat_i[31:24];
        end
      end
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `SSLSP_REG_GLOBAL:   wb_dat_o <= {31'h0, ignore_source_entry_flags_ff};
          `SSLSP_REG_QUEUES:   wb_dat_o <= {21'h0, address_copy_extract_queue_ff, 1'b0,
                                            locked_move_extract_queue_ff, 1'b0,
                                            learn_extract_queue_ff};
          `SSLSP_REG_PORT_BASE: wb_dat_o <= {24'h0, port_cfg_ff[port_sel_ff]};
          `SSLSP_REG_STATUS:   wb_dat_o <= {12'h0, storm_hit_ff, police_cnt_ff};
          `SSLSP_REG_PORT_SEL: wb_dat_o <= {{(32-PW){1'b0}}, port_sel_ff};
          `SSLSP_REG_STORM_BASE:        wb_dat_o <= storm_cfg_ff[0] & 32'hffff_007f;
          `SSLSP_REG_STORM_BASE + 6'h4: wb_dat_o <= storm_cfg_ff[1] & 32'hffff_007f;
          `SSLSP_REG_STORM_BASE + 6'h8: wb_dat_o <= storm_cfg_ff[2] & 32'hffff_007f;
          `SSLSP_REG_STORM_BASE + 6'hc: wb_dat_o <= storm_cfg_ff[3] & 32'hffff_007f;
          default:             wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

endmodule // sslsp_core

// ### verif/sslsp_lookup_model.sv
`timescale 1ns/1ps
module sslsp_lookup_model (
  // Frame under lookup
  input  wire        frm_valid_i,
  input  wire [47:0] src_addr_i,
  // Answer in the frame's own cycle
  output wire        hit_o,
  output wire        locked_o,
  output wire [3:0]  entry_destination_index_o,
  output wire        discard_o,
  output wire        copy_o,
  output wire        limit_o
);
  // Entry contents ride in the low address bits so the bench knows every entry;
  // between frames the answer is inverted, never a stale copy
  assign {limit_o, entry_destination_index_o, copy_o, discard_o, locked_o, hit_o} =
    frm_valid_i ? src_addr_i[8:0] : ~src_addr_i[8:0];
endmodule // sslsp_lookup_model

// ### verif/sslsp_core_checker.sv
`timescale 1ns/1ps
module sslsp_core_checker #(
  parameter PW = 4
) (
  // Clock, reset, bus handshake
  input wire          clk_i,
  input wire          rst_i,
  input wire          wb_cyc_i,
  input wire          wb_stb_i,
  input wire          wb_ack_o,
  // Frame and lookup result
  input wire          frm_valid_i,
  input wire [PW-1:0] logical_ingress_port_i,
  input wire          backbone_domain_i,
  input wire [47:0]   source_station_address_i,
  input wire [11:0]   vid_i,
  input wire          learn_disable_flag_i,
  input wire          policer_no_learn_i,
  input wire          entry_hit_i,
  input wire          entry_locked_i,
  input wire [PW-1:0] entry_destination_index_i,
  input wire          limit_exceeded_i,
  // Outputs
  input wire          lookup_req_o,
  input wire          lookup_backbone_o,
  input wire [47:0]   lookup_addr_o,
  input wire [11:0]   lookup_vid_o,
  input wire [11:0]   learn_vid_o,
  input wire [PW-1:0] learn_port_o,
  input wire          out_learn_frame_o,
  input wire          learn_insert_o,
  input wire          learn_backbone_o,
  input wire [47:0]   learn_addr_o,
  input wire          out_valid_o
);
  wire mvd = entry_destination_index_i != logical_ingress_port_i;
  wire nrm = !entry_hit_i || (!entry_locked_i && mvd);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_lookup_each: assert property (frm_valid_i |=> lookup_req_o && out_valid_o)
    else $error("frame not looked up");
  a_learn_dis: assert property (frm_valid_i && learn_disable_flag_i |=> !learn_insert_o)
    else $error("insert despite learn disable");
  a_pol_nolearn: assert property (frm_valid_i && policer_no_learn_i |=> !learn_insert_o)
    else $error("insert despite policer");
  a_insert_domain: assert property (learn_insert_o |->
    learn_backbone_o == $past(backbone_domain_i)
    && learn_addr_o == $past(source_station_address_i)) else $error("insert wrong entry");
  a_insert_key: assert property (learn_insert_o |-> learn_vid_o == $past(vid_i)
    && learn_port_o == $past(logical_ingress_port_i)) else $error("insert key wrong");
  a_lookup_key: assert property (lookup_req_o |->
    lookup_backbone_o == $past(backbone_domain_i) && lookup_vid_o == $past(vid_i)
    && lookup_addr_o == $past(source_station_address_i)) else $error("lookup key wrong");
  a_learn_frame: assert property (out_learn_frame_o |-> $past(frm_valid_i
    && !learn_disable_flag_i && !policer_no_learn_i
    && (nrm || (entry_hit_i && entry_locked_i && mvd)))) else $error("learn frame without cause");
  a_insert_cause: assert property (learn_insert_o |-> $past(frm_valid_i && nrm))
    else $error("insert without learn frame");
  a_limit_block: assert property (frm_valid_i && limit_exceeded_i |=> !learn_insert_o)
    else $error("insert over limit");
  a_locked_move: assert property (frm_valid_i && entry_hit_i && entry_locked_i |=>
    !learn_insert_o) else $error("locked entry moved");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  c_insert: cover property (learn_insert_o);
  c_locked: cover property (frm_valid_i && entry_hit_i && entry_locked_i);
  c_bus: cover property (wb_ack_o);
endmodule // sslsp_core_checker
bind sslsp_core sslsp_core_checker #(.PW(PW)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .frm_valid_i(frm_valid_i), .logical_ingress_port_i(logical_ingress_port_i),
  .backbone_domain_i(backbone_domain_i), .source_station_address_i(source_station_address_i),
  .learn_disable_flag_i(learn_disable_flag_i), .policer_no_learn_i(policer_no_learn_i),
  .entry_hit_i(entry_hit_i), .entry_locked_i(entry_locked_i), .limit_exceeded_i(limit_exceeded_i),
  .entry_destination_index_i(entry_destination_index_i), .lookup_req_o(lookup_req_o),
  .vid_i(vid_i), .lookup_backbone_o(lookup_backbone_o), .lookup_addr_o(lookup_addr_o),
  .lookup_vid_o(lookup_vid_o), .learn_vid_o(learn_vid_o), .learn_port_o(learn_port_o),
  .out_learn_frame_o(out_learn_frame_o),
  .learn_insert_o(learn_insert_o), .learn_backbone_o(learn_backbone_o),
  .learn_addr_o(learn_addr_o), .out_valid_o(out_valid_o));

// ### verif/testbench.sv
`timescale 1ns/1ps
`include "sslsp_defs.vh"
module testbench;
  reg         clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, frm_valid_i, bb, ld, pn, fl, pg, ign;
  reg  [5:0]  wb_adr_i;
  reg  [3:0]  wb_sel_i, pp, lp, p, l;
  reg  [31:0] wb_dat_i, r;
  reg  [47:0] src, dst, s;
  reg  [11:0] vid, dm_in;
  reg  [7:0]  q_in, pc[0:11];
  reg  [20:0] exp_q[$];
  reg  [31:0] rd_q[$];
  wire [31:0] wb_dat_o;
  wire        wb_ack_o, hit, lck, disc, cpy, lim, ins, ov;
  wire [3:0]  didx;
  wire [11:0] dm_o;
  wire [7:0]  q_o;
  integer     n_fail, num_checks, seed, i, k;
  sslsp_core DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .frm_valid_i(frm_valid_i),
    .physical_ingress_port_i(pp), .logical_ingress_port_i(lp), .backbone_domain_i(bb),
    .source_station_address_i(src), .destination_port_mask_station_address_i(dst), .vid_i(vid),
    .learn_disable_flag_i(ld), .policer_no_learn_i(pn), .flooded_i(fl), .port_group_table_has_cpu_i(pg),
    .destination_port_mask_i(dm_in), .processor_queue_mask_i(q_in), .entry_hit_i(hit),
    .entry_locked_i(lck), .entry_destination_index_i(didx), .source_discard_flag_i(disc),
    .entry_copy_to_processor_i(cpy), .limit_exceeded_i(lim), .lookup_req_o(),
    .lookup_backbone_o(), .lookup_addr_o(), .lookup_vid_o(), .learn_insert_o(ins),
    .learn_backbone_o(), .learn_addr_o(), .learn_vid_o(), .learn_port_o(), .out_valid_o(ov),
    .out_learn_frame_o(), .destination_port_mask_o(dm_o), .processor_queue_mask_o(q_o));
  sslsp_lookup_model PEER (.frm_valid_i(frm_valid_i), .src_addr_i(src), .hit_o(hit),
    .locked_o(lck), .entry_destination_index_o(didx), .discard_o(disc), .copy_o(cpy), .limit_o(lim));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  task chk(input [63:0] nm, input [31:0] seen, input [31:0] want);
    begin
      num_checks = num_checks + 1;
      if (seen !== want) begin
        n_fail = n_fail + 1;
        $display("wrong value %0s expected %h seen %h", nm, want, seen);
      end
    end
  endtask
  always @(posedge clk_i) begin : mon
    reg [20:0] e;
    if (!rst_i && ov === 1'b1) begin
      e = exp_q.pop_front();
      chk("insert", ins, e[20]);
      chk("destination_port_mask", dm_o, e[19:8]);
      chk("processor_queue_mask", q_o, e[7:0]);
    end
    if (!rst_i && wb_ack_o === 1'b1 && !wb_we_i) chk("read", wb_dat_o, rd_q.pop_front());
  end
  task wb(input we, input [5:0] a, input [31:0] d, input [3:0] sl);
    begin
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, sl};
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1) @(posedge clk_i);
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      @(posedge clk_i);
    end
  endtask
  task rd(input [5:0] a, input [31:0] e);
    begin
      rd_q.push_back(e);
      wb(1'b0, a, 32'h0, 4'hf);
    end
  endtask
  task frame(input [3:0] fp, fl_p, input [47:0] fs, fd, input f, g, fld, fpn,
             input [11:0] m, input [7:0] q, input [20:0] e);
    begin
      @(posedge clk_i);
      {frm_valid_i, pp, lp, src, dst, fl, pg, ld, pn, dm_in, q_in} <= {1'b1, fp, fl_p, fs, fd, f, g, fld, fpn, m, q};
      {bb, vid} <= fs[21:9];
      exp_q.push_back(e);
    end
  endtask
  task st(input [47:0] d, input [11:0] m, input [20:0] e);
    frame(4'h2, 4'h2, 48'h21, d, 1'b1, m[11], 1'b0, 1'b0, m, 8'h81, e);
  endtask
  task idle;
    begin
      @(posedge clk_i);
      frm_valid_i <= 1'b0;
    end
  endtask
  function [20:0] ref_out(input [3:0] fp, fl_p, input [47:0] fs, input fld, fpn,
                          input [11:0] m, input [7:0] q);
    reg [7:0] c;
    reg       on, a, v;
    begin
      c = pc[fp];
      on = c[0] && !fld && !fpn;
      a = on && (!fs[0] || (!fs[1] && fs[7:4] != fl_p));
      v = on && fs[0] && fs[1] && fs[7:4] != fl_p;
      if ((a && !fs[8] && c[3]) || (a && fs[8] && c[5]) || (v && c[7])) m = 12'h000;
      if ((a && !fs[8] && c[2]) || (a && fs[8] && c[4])) {m[11], q[1]} = 2'b11;
      if (v && c[6]) {m[11], q[2]} = 2'b11;
      if (fs[0] && !ign && fs[2]) m = 12'h000;
      if (fs[0] && !ign && fs[3]) q[3] = 1'b1;
      ref_out = {a && !fs[8] && c[1], m, q};
    end
  endfunction
  task test_done;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    seed = 80;
    n_fail = 0;
    num_checks = 0;
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, frm_valid_i, bb, ld, pn, fl, pg, ign} = 10'h000;
    {wb_adr_i, wb_sel_i, wb_dat_i, pp, lp, src, dst, vid, dm_in, q_in} = 178'h0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`SSLSP_REG_STORM_BASE, `SSLSP_ST_RESET);
    rd(`SSLSP_REG_PORT_BASE, {24'h0, `SSLSP_PC_RESET});
    rd(6'h3c, 32'h0);
    $display("test reset_values done");
    wb(1'b1, `SSLSP_REG_QUEUES, 32'h0000_0321, 4'hf);
    // Huge bursts keep the policers out of the way of the learning tests
    for (k = 0; k < 4; k = k + 1) wb(1'b1, `SSLSP_REG_STORM_BASE + {k[3:0], 2'b00}, 32'hffff_005a, 4'hf);
    for (k = 0; k < 12; k = k + 1) begin
      r = $random(seed);
      pc[k] = r[7:0] & ~{r[6], 1'b0, r[4], 1'b0, r[2], 3'b000};
      wb(1'b1, `SSLSP_REG_PORT_SEL, {28'h0, k[3:0]}, 4'hf);
      wb(1'b1, `SSLSP_REG_PORT_BASE, {24'h0, pc[k]}, 4'hf);
      rd(`SSLSP_REG_PORT_BASE, {24'h0, pc[k]});
    end
    for (k = 0; k < 2; k = k + 1) begin
      ign = k[0];
      wb(1'b1, `SSLSP_REG_GLOBAL, {31'h0, ign}, 4'hf);
      for (i = 0; i < 200; i = i + 1) begin
        r = $random(seed);
        p = r[3:0] % 4'hc;
        l = r[7:4] % 4'hc;
        s = {r[31:16], $random(seed)};
        if (s[9]) s[7:4] = l;
        frame(p, l, s, {r, s[15:0]}, 1'b0, r[8], r[11:9] == 3'h0, r[14:12] == 3'h0, s[43:32],
              s[47:40], ref_out(p, l, s, r[11:9] == 3'h0, r[14:12] == 3'h0, s[43:32], s[47:40]));
      end
      idle;
    end
    $display("test learn_random done");
    wb(1'b1, `SSLSP_REG_STORM_BASE, 32'h0002_0020, 4'hf);
    wb(1'b1, `SSLSP_REG_STORM_BASE + 6'h04, 32'h0001_0000, 4'hf);
    wb(1'b1, `SSLSP_REG_STORM_BASE + 6'h08, 32'h0001_0040, 4'hf);
    for (k = 0; k < 3; k = k + 1) st(`SSLSP_BCAST, 12'h0ff, {1'b0, k == 2 ? 12'h000 : 12'h0ff, 8'h81});
    st(`SSLSP_BCAST, 12'h8ff, {1'b0, 12'h800, 8'h81});
    st(48'h0100_0000_0000, 12'h0ff, {1'b0, 12'h0ff, 8'h81});
    st(48'h0100_0000_0000, 12'h0ff, {1'b0, 12'h0ff, 8'h00});
    st(48'h0000_0000_0002, 12'h0ff, {1'b0, 12'h0ff, 8'h81});
    st(48'h0000_0000_0002, 12'h0ff, {1'b0, 12'h000, 8'h00});
    idle;
    rd(`SSLSP_REG_STATUS, 32'h0007_0004);
    wb(1'b1, `SSLSP_REG_STATUS, 32'h0, 4'h1);
    rd(`SSLSP_REG_STATUS, 32'h0000_0004);
    // At 1024 kframes/s the two tokens left in the broadcast bucket drain well inside the wait
    wb(1'b1, `SSLSP_REG_STORM_BASE, 32'h0002_003a, 4'hf);
    repeat (500) @(posedge clk_i);
    st(`SSLSP_BCAST, 12'h0ff, {1'b0, 12'h0ff, 8'h81});
    idle;
    $display("test storm done");
    repeat (4) @(posedge clk_i);
    test_done;
  end
  // The run needs a little over a thousand cycles; this leaves a wide margin
  initial begin
    #200000;
    n_fail = n_fail + 1;
    test_done;
  end
endmodule // testbench
